// File: src/sdrpm_dev.sv
// module: device end, command decode, refresh and power modes
`timescale 1ns/10ps
// Operation
// RULE1: write interrupt: bank precharges tWR after
// RULE2: last data is word before interrupt
// RULE3: controller precharges all before refresh
// RULE4: controller waits tRP before refresh
// RULE5: refresh row from internal counter
// RULE6: only nop during tRFC
// RULE7: controller refreshes every row per tREF
// RULE8: refresh with cke low enters self
// RULE9: self refresh runs own timer, min tRAS
// RULE10: exit self: clock, cke high, nops
// RULE11: resume distributed refresh after self
// RULE12: cke low with nop enters power-down
// RULE13: power-down disables io buffers
// RULE14: power-down shorter than 64 ms
// RULE15: nop with cke high exits power-down
// RULE16: deep power-down command, data lost
// RULE17: cke held low in deep power-down
// RULE18: deep power-down exit needs initialization
// RULE19: cke low in burst suspends next edge
// RULE20: suspended: ignore inputs, hold dq, counters
// RULE21: cke high resumes on next edge
module sdrpm_dev
  import sdrpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  sdrpm_if.dev bus,
  output logic [2:0] mode,
  output logic [NBANK-1:0] bank_open,
  output logic [ROW_W-1:0] ref_row,
  output logic wr_en,
  output logic [BA_W-1:0] wr_bank,
  output logic [DQ_W-1:0] wr_data,
  output logic [NBANK-1:0] pre_start,
  output logic init_needed
);
  sdrpm_mode_t mode_r;
  logic cke_q_r;
  logic [3:0] cmd;
  logic [NBANK-1:0] open_r;
  logic [NBANK-1:0] ap_wr_r;
  logic [NBANK-1:0] pre_r;
  logic [3:0] twr_cnt_r [NBANK];
  logic [BA_W-1:0] burst_bank_r;
  logic burst_r;
  logic [2:0] burst_cnt_r;
  logic [ROW_W-1:0] ref_row_r;
  logic [7:0] busy_cnt_r;
  logic [7:0] sr_tick_r;
  logic [DQ_W-1:0] wdata_r;
  logic wr_en_r;
  logic [BA_W-1:0] wr_bank_r;
  logic init_r;
  logic dq_oe_r;
  logic [DQ_W-1:0] dq_o_r;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // cke of the previous edge gates this edge, as in a real part
  assign cmd = {bus.cs_b, bus.ras_b, bus.cas_b, bus.we_b};
  wire is_nop = bus.cs_b || (cmd == CMD_NOP);
  wire run = cke_q_r && (mode_r == SDRPM_ACTIVE);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cke_q_r <= 1'b0;
    else
      cke_q_r <= bus.cke;
  end

  // ---------------------------------------------------------------
  // mode machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r <= SDRPM_ACTIVE;
      busy_cnt_r <= 8'h00;
      init_r <= 1'b0;
    end
    else
    begin
      if (busy_cnt_r != 8'h00)
        busy_cnt_r <= busy_cnt_r - 8'h01;
      unique case (mode_r)
        SDRPM_ACTIVE:
        begin
          if (cke_q_r && !bus.cke && !is_nop && cmd == CMD_REF)
          begin
            mode_r <= SDRPM_SELF; // RULE8
            busy_cnt_r <= 8'(TRAS_CYC); // RULE9
          end
          else if (cke_q_r && !bus.cke && !is_nop && cmd == CMD_BST &&
                   open_r == '0)
          begin
            mode_r <= SDRPM_DPD; // RULE16
            init_r <= 1'b1;
          end
          else if (cke_q_r && !bus.cke && burst_r)
            mode_r <= SDRPM_SUSPEND; // RULE19
          else if (cke_q_r && !bus.cke && is_nop && busy_cnt_r == 8'h00)
            mode_r <= SDRPM_PDN; // RULE12
          else if (run && !is_nop && cmd == CMD_REF)
          begin
            mode_r <= SDRPM_REFRESH;
            busy_cnt_r <= 8'(TRFC_CYC);
          end
          else if (run && !is_nop && cmd == CMD_MRS)
            init_r <= 1'b0;
        end
        SDRPM_REFRESH:
          if (busy_cnt_r == 8'h01)
            mode_r <= SDRPM_ACTIVE;
        SDRPM_SELF:
          // all pins but cke ignored; tRAS minimum stay
          if (bus.cke && busy_cnt_r == 8'h00)
            mode_r <= SDRPM_ACTIVE; // RULE9
        SDRPM_PDN:
          if (bus.cke && is_nop)
            mode_r <= SDRPM_ACTIVE; // RULE15
        SDRPM_DPD:
          if (bus.cke)
            mode_r <= SDRPM_ACTIVE;
        SDRPM_SUSPEND:
          if (bus.cke)
            mode_r <= SDRPM_ACTIVE; // RULE21
        default:
          mode_r <= SDRPM_ACTIVE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bank state; a write with auto precharge precharges only when cut by a write to another bank
  // ---------------------------------------------------------------
  wire wr_cmd = run && !is_nop && cmd == CMD_WR;
  genvar b;
  generate
    for (b = 0; b < NBANK; b++)
    begin : g_bank
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
        begin
          open_r[b] <= 1'b0;
          ap_wr_r[b] <= 1'b0;
          twr_cnt_r[b] <= 4'h0;
          pre_r[b] <= 1'b0;
        end
        else
        begin
          pre_r[b] <= 1'b0;
          if (mode_r == SDRPM_DPD)
            open_r[b] <= 1'b0;
          if (twr_cnt_r[b] != 4'h0)
          begin
            twr_cnt_r[b] <= twr_cnt_r[b] - 4'h1;
            if (twr_cnt_r[b] == 4'h1)
            begin
              pre_r[b] <= 1'b1; // RULE1
              open_r[b] <= 1'b0;
              ap_wr_r[b] <= 1'b0;
            end
          end
          if (run && !is_nop && cmd == CMD_ACT && bus.ba == BA_W'(b))
            open_r[b] <= 1'b1;
          else if (run && !is_nop && cmd == CMD_PRE &&
                   (bus.addr[AP_BIT] || bus.ba == BA_W'(b)))
            open_r[b] <= 1'b0;
          else if (wr_cmd && bus.ba == BA_W'(b))
            ap_wr_r[b] <= bus.addr[AP_BIT];
          else if (wr_cmd && ap_wr_r[b] && burst_r &&
                   burst_bank_r == BA_W'(b) && twr_cnt_r[b] == 4'h0)
            twr_cnt_r[b] <= 4'(TWR_CYC); // RULE1
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // write data path and burst counter
  // ---------------------------------------------------------------
  // a new write takes the bus; the previous word was the last one
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      burst_r <= 1'b0;
      burst_cnt_r <= 3'h0;
      burst_bank_r <= '0;
      wr_en_r <= 1'b0;
      wr_bank_r <= '0;
      wdata_r <= '0;
    end
    else
    begin
      wr_en_r <= 1'b0;
      if (wr_cmd)
      begin
        burst_r <= 1'b1; // RULE2
        burst_bank_r <= bus.ba;
        burst_cnt_r <= 3'h3;
        wr_en_r <= 1'b1;
        wr_bank_r <= bus.ba;
        wdata_r <= bus.dq_ctl_o;
      end
      else if (run && burst_r)
      begin
        // suspended edges do not advance the counter
        wr_en_r <= 1'b1; // RULE20
        wr_bank_r <= burst_bank_r;
        wdata_r <= bus.dq_ctl_o;
        burst_cnt_r <= burst_cnt_r - 3'h1;
        if (burst_cnt_r == 3'h1)
          burst_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // refresh row counter, shared by auto and self refresh
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_row_r <= '0;
      sr_tick_r <= 8'h00;
    end
    else if (mode_r == SDRPM_SELF)
    begin
      // own timer stands in for the internal oscillator
      sr_tick_r <= sr_tick_r + 8'h01;
      if (sr_tick_r == 8'(SR_PERIOD_CYC - 1))
      begin
        sr_tick_r <= 8'h00;
        ref_row_r <= ref_row_r + 13'h0001; // RULE9
      end
    end
    else if (run && !is_nop && cmd == CMD_REF && bus.cke)
      ref_row_r <= ref_row_r + 13'h0001; // RULE5
  end

  // ---------------------------------------------------------------
  // dq drive: held while suspended, off in power-down
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_oe_r <= 1'b0;
      dq_o_r <= '0;
    end
    else if (mode_r == SDRPM_PDN || mode_r == SDRPM_SELF ||
             mode_r == SDRPM_DPD)
      dq_oe_r <= 1'b0; // RULE13
  end

  assign bus.dq_dev_o = dq_o_r;
  assign bus.dq_dev_oe = dq_oe_r;
  assign mode = mode_r;
  assign bank_open = open_r;
  assign ref_row = ref_row_r;
  assign wr_en = wr_en_r;
  assign wr_bank = wr_bank_r;
  assign wr_data = wdata_r;
  assign pre_start = pre_r;
  assign init_needed = init_r; // RULE18
endmodule : sdrpm_dev

// File: src/sdrpm_pkg.sv
// package: shared constants and types for the sdram power-mode link
package sdrpm_pkg;
  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int DQ_W = 16;
  localparam int NBANK = 4;
  localparam int ROW_W = 13;
  // ---------------------------------------------------------------
  // timing (ns, at 200 MHz / 5 ns)
  // ---------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int TWR_NS = 15;
  localparam int TRP_NS = 20;
  localparam int TRFC_NS = 72;
  localparam int TRAS_NS = 42;
  localparam int TXSR_CLK = 2;
  localparam int TREF_MS = 64;
  localparam int TWR_CYC = (TWR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRFC_CYC = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRAS_CYC = (TRAS_NS + CLK_NS - 1) / CLK_NS;
  // one refresh slot per row: 64 ms / 8192 rows = 7812 ns
  localparam int TREFI_NS = TREF_MS * 1000000 / 8192;
  localparam int TREFI_CYC = TREFI_NS / CLK_NS;
  localparam int SR_PERIOD_CYC = 64;
  localparam logic [9:0] IDLE_WAIT_RST = 10'h000;
  // ---------------------------------------------------------------
  // command encoding {cs_b, ras_b, cas_b, we_b}
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_INH = 4'h8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int AP_BIT = 10;
  // ---------------------------------------------------------------
  // device modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SDRPM_ACTIVE, SDRPM_REFRESH, SDRPM_SELF, SDRPM_PDN, SDRPM_DPD,
    SDRPM_SUSPEND
  } sdrpm_mode_t;
endpackage : sdrpm_pkg

// File: src/sdrpm_if.sv
// interface: sdram command/data bus between controller and device
`timescale 1ns/10ps
interface sdrpm_if;
  import sdrpm_pkg::*;
  logic cke;
  logic cs_b;
  logic ras_b;
  logic cas_b;
  logic we_b;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_ctl_o;
  logic dq_ctl_oe;
  logic [DQ_W-1:0] dq_dev_o;
  logic dq_dev_oe;
  modport ctrl (
    output cke, cs_b, ras_b, cas_b, we_b, ba, addr, dq_ctl_o, dq_ctl_oe,
    input dq_dev_o, dq_dev_oe
  );
  modport dev (
    input cke, cs_b, ras_b, cas_b, we_b, ba, addr, dq_ctl_o, dq_ctl_oe,
    output dq_dev_o, dq_dev_oe
  );
endinterface : sdrpm_if

// File: src/sdrpm_ctl.sv
// module: controller end, refresh scheduling and power requests
`timescale 1ns/10ps
module sdrpm_ctl
  import sdrpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  sdrpm_if.ctrl bus,
  input wire logic [3:0] req_cmd,
  input wire logic [BA_W-1:0] req_ba,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DQ_W-1:0] req_data,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic self_req,
  input wire logic pdn_req,
  input wire logic dpd_req,
  input wire logic susp_req,
  output logic busy
);
  typedef enum logic [2:0] {
    SDRPM_C_RUN, SDRPM_C_PRE, SDRPM_C_REF, SDRPM_C_SELF, SDRPM_C_XSR,
    SDRPM_C_PDN, SDRPM_C_DPD
  } sdrpm_cst_t;
  sdrpm_cst_t st_r;
  logic [15:0] trefi_r;
  logic ref_due_r;
  logic self_mode_r;
  logic [7:0] wait_r;
  logic [NBANK-1:0] open_r;
  logic cke_r;
  logic [3:0] cmd_r;
  logic [BA_W-1:0] ba_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DQ_W-1:0] dq_r;
  logic dq_oe_r;

  // ---------------------------------------------------------------
  // distributed refresh timer; free-running, not restarted on self refresh exit
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trefi_r <= '0;
      ref_due_r <= 1'b0;
    end
    else
    begin
      // a slot ending on the issue cycle must not be lost: set wins
      trefi_r <= trefi_r + 16'h0001;
      if (st_r == SDRPM_C_REF)
        ref_due_r <= 1'b0;
      if (trefi_r == 16'(TREFI_CYC - 1))
      begin
        trefi_r <= '0;
        ref_due_r <= 1'b1; // RULE7 RULE11
      end
    end
  end

  wire pass = st_r == SDRPM_C_RUN && wait_r == 8'h00 && !ref_due_r &&
              !self_req && !pdn_req && !dpd_req;
  assign req_ready = pass;
  assign busy = st_r != SDRPM_C_RUN;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= SDRPM_C_RUN;
      wait_r <= 8'h00;
      self_mode_r <= 1'b0;
      open_r <= '0;
      cke_r <= 1'b1;
      cmd_r <= CMD_NOP;
      ba_r <= '0;
      addr_r <= '0;
      dq_r <= '0;
      dq_oe_r <= 1'b0;
    end
    else
    begin
      cmd_r <= CMD_NOP; // RULE6 RULE10
      dq_oe_r <= 1'b0;
      if (wait_r != 8'h00)
        wait_r <= wait_r - 8'h01;
      unique case (st_r)
        SDRPM_C_RUN:
          if (wait_r == 8'h00)
          begin
            if (ref_due_r || self_req || dpd_req)
            begin
              if (open_r != '0)
              begin
                cmd_r <= CMD_PRE; // RULE3
                addr_r[AP_BIT] <= 1'b1;
                open_r <= '0;
                wait_r <= 8'(TRP_CYC); // RULE4
              end
              else
                st_r <= ref_due_r ? SDRPM_C_REF :
                        (self_req ? SDRPM_C_SELF : SDRPM_C_DPD);
            end
            else if (pdn_req)
            begin
              cke_r <= 1'b0; // RULE12
              st_r <= SDRPM_C_PDN;
            end
            else if (req_valid)
            begin
              cmd_r <= req_cmd;
              ba_r <= req_ba;
              addr_r <= req_addr;
              dq_r <= req_data;
              dq_oe_r <= req_cmd == CMD_WR;
              cke_r <= !susp_req; // RULE19
              if (req_cmd == CMD_ACT)
                open_r[req_ba] <= 1'b1;
              if (req_cmd == CMD_PRE)
                open_r <= req_addr[AP_BIT] ? '0 : open_r & ~(4'h1 << req_ba);
            end
            else
              cke_r <= !susp_req; // RULE21
          end
        SDRPM_C_REF:
        begin
          cmd_r <= CMD_REF;
          wait_r <= 8'(TRFC_CYC); // RULE6
          st_r <= SDRPM_C_RUN;
        end
        SDRPM_C_SELF:
          if (!self_mode_r)
          begin
            cmd_r <= CMD_REF;
            cke_r <= 1'b0; // RULE8
            self_mode_r <= 1'b1;
            wait_r <= 8'(TRAS_CYC); // RULE9
          end
          else if (!self_req && wait_r == 8'h00)
          begin
            cke_r <= 1'b1; // RULE10
            self_mode_r <= 1'b0;
            wait_r <= 8'(TXSR_CLK);
            st_r <= SDRPM_C_XSR;
          end
        SDRPM_C_XSR:
          if (wait_r == 8'h01)
            st_r <= SDRPM_C_RUN; // RULE11
        SDRPM_C_PDN:
          // nothing refreshes in power-down, so a due slot breaks it
          if (!pdn_req || ref_due_r)
          begin
            cke_r <= 1'b1; // RULE15 RULE14
            st_r <= SDRPM_C_RUN;
          end
        SDRPM_C_DPD:
          if (cke_r)
          begin
            cmd_r <= CMD_BST; // RULE16
            cke_r <= 1'b0;
          end
          else if (!dpd_req)
          begin
            cke_r <= 1'b1; // RULE18
            st_r <= SDRPM_C_RUN;
          end
          else
            cke_r <= 1'b0; // RULE17
        default:
          st_r <= SDRPM_C_RUN;
      endcase
    end
  end

  assign bus.cke = cke_r;
  assign {bus.cs_b, bus.ras_b, bus.cas_b, bus.we_b} = cmd_r;
  assign bus.ba = ba_r;
  assign bus.addr = addr_r;
  assign bus.dq_ctl_o = dq_r;
  assign bus.dq_ctl_oe = dq_oe_r;
endmodule : sdrpm_ctl

// File: dv/sdrpm_checker.sv
// checker: bus-level properties of the sdram power-mode link
`timescale 1ns/10ps
module sdrpm_checker
  import sdrpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic dq_ctl_oe,
  input wire logic dq_dev_oe
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [3:0] cmd;
  logic idle;
  logic self_r;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // command word and the non-executable set
  assign cmd = {cs_b, ras_b, cas_b, we_b};
  assign idle = cs_b || cmd == CMD_NOP;
  // self refresh tracker, needed to tell its exit from power-down exit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      self_r <= 1'h0;
    else if (!cke && cmd == CMD_REF)
      self_r <= 1'h1;
    else if (cke)
      self_r <= 1'h0;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  rfc_nop_a: assert property (cke && !$fell(cke) && cmd == CMD_REF
    |=> idle[*8] ##1 idle[*7]) else $error("command inside refresh time");
  pre_gap_a: assert property (cmd == CMD_REF |->
    $past(cmd, 1) != CMD_PRE && $past(cmd, 2) != CMD_PRE
    && $past(cmd, 3) != CMD_PRE) else $error("refresh too soon after pre");
  self_hold_a: assert property ($fell(cke) && cmd == CMD_REF
    |=> !cke[*8]) else $error("self refresh left too early");
  self_exit_a: assert property ($rose(cke) && self_r
    |-> idle ##1 idle) else $error("no nops after self refresh exit");
  dpd_hold_a: assert property ($fell(cke) && cmd == CMD_BST
    |=> !cke[*4]) else $error("cke rose in deep power-down");
  cke_fall_a: assert property ($fell(cke) |-> idle
    || cmd == CMD_REF || cmd == CMD_BST) else $error("bad cke fall cmd");
  pdn_dq_a: assert property (!cke && $past(cke, 1) == 1'h0
    |-> !dq_dev_oe) else $error("device drives dq while powered down");
  wr_drive_a: assert property (cke && cmd == CMD_WR
    |-> dq_ctl_oe) else $error("write without data driven");
endmodule : sdrpm_checker

// File: dv/tb.sv
// testbench: both ends joined, refresh, write and power-mode scenarios
`timescale 1ns/10ps
module tb;
  import sdrpm_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] req_cmd = CMD_NOP;
  logic [BA_W-1:0] req_ba = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DQ_W-1:0] req_data = '0;
  logic req_valid = 1'h0;
  logic self_req = 1'h0;
  logic pdn_req = 1'h0;
  logic dpd_req = 1'h0;
  logic susp_req = 1'h0;
  logic req_ready, busy, wr_en, init_needed;
  logic [2:0] mode;
  logic [NBANK-1:0] bank_open, pre_start;
  logic [ROW_W-1:0] ref_row, r0;
  logic [BA_W-1:0] wr_bank;
  logic [DQ_W-1:0] wr_data;
  int failures = 0;
  int num_checks = 0;
  int seed = 31749;
  int pend = 0;
  int words[NBANK] = '{0, 0, 0, 0};
  int t1, t2;
  logic [17:0] notes[$];
  // ---------------------------------------------------------------
  // ends, carrier and checker
  // ---------------------------------------------------------------
  sdrpm_if bus_if();
  sdrpm_ctl sdrpm_ctl_i (.clk_sys, .rst_b, .bus(bus_if), .req_cmd,
    .req_ba, .req_addr, .req_data, .req_valid, .req_ready, .self_req,
    .pdn_req, .dpd_req, .susp_req, .busy);
  sdrpm_dev sdrpm_dev_i (.clk_sys, .rst_b, .bus(bus_if), .mode,
    .bank_open, .ref_row, .wr_en, .wr_bank, .wr_data, .pre_start,
    .init_needed);
  sdrpm_checker sdrpm_checker_i (.clk_sys, .rst_b, .cke(bus_if.cke),
    .cs_b(bus_if.cs_b), .ras_b(bus_if.ras_b), .cas_b(bus_if.cas_b),
    .we_b(bus_if.we_b), .dq_ctl_oe(bus_if.dq_ctl_oe),
    .dq_dev_oe(bus_if.dq_dev_oe));
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // holds the request until taken; valid stays up for back-to-back use
  task automatic send(input logic [3:0] c, input logic [1:0] b,
                      input logic [12:0] a);
    int n;
    n = 0;
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    req_data = DQ_W'($random(seed));
    req_valid = 1'h1;
    if (c == CMD_WR)
      notes.push_back({b, req_data});
    @(negedge clk_sys);
    while (req_ready !== 1'h1 && n < 4000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(n < 4000, 1'h1);
    @(posedge clk_sys);
    #1;
  endtask : send
  task automatic idle(input int k);
    req_valid = 1'h0;
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : idle
  // bounded wait on the mode output, then back to the drive slot
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(mode, m);
    @(posedge clk_sys);
    #1;
  endtask : wait_mode
  // ---------------------------------------------------------------
  // monitor: first word after each bus write meets the oldest note
  // ---------------------------------------------------------------
  always @(negedge clk_sys)
  begin
    if (wr_en === 1'h1)
    begin
      words[wr_bank]++;
      if (pend > 0)
      begin
        pend--;
        check({wr_bank, wr_data}, notes.pop_front());
      end
    end
    if (bus_if.cke === 1'h1 && {bus_if.cs_b, bus_if.ras_b, bus_if.cas_b,
        bus_if.we_b} === CMD_WR)
      pend++;
  end
  // hang guard, far beyond the longest refresh wait
  initial
  begin
    #(CLK_NS * 40000);
    failures++;
    give_verdict;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst_b = 1'h1;
    check(mode, 3'h0);
    check(bus_if.cke, 1'h1);
    // write with auto precharge cut by a write to another bank
    send(CMD_ACT, 2'h1, 13'h0000);
    send(CMD_ACT, 2'h2, 13'h0000);
    send(CMD_WR, 2'h1, 13'h0400);
    send(CMD_WR, 2'h2, 13'h0000);
    req_valid = 1'h0;
    t1 = -1;
    t2 = -1;
    for (int k = 0; k < 20; k++)
    begin
      @(negedge clk_sys);
      if ({bus_if.cs_b, bus_if.ras_b, bus_if.cas_b, bus_if.we_b} === CMD_WR
          && bus_if.ba === 2'h2)
        t1 = k;
      if (pre_start[1] === 1'h1 && t2 < 0)
        t2 = k;
    end
    // the bus shows a command one cycle before the device registers it
    check(t2 - t1, TWR_CYC + 1);
    check(bank_open, 4'h4);
    check(words[1], 1);
    check(words[2], 4);
    idle(1);
    // clock suspend in the middle of a bank 0 burst
    send(CMD_ACT, 2'h0, 13'h0000);
    send(CMD_WR, 2'h0, 13'h0000);
    req_valid = 1'h0;
    susp_req = 1'h1;
    wait_mode(SDRPM_SUSPEND);
    idle(5);
    check(words[0], 2);
    susp_req = 1'h0;
    wait_mode(SDRPM_ACTIVE);
    idle(4);
    check(words[0], 4);
    // first refresh slot: precharge all, then the refresh itself
    r0 = ref_row;
    wait_mode(SDRPM_REFRESH);
    check(bank_open, 4'h0);
    check(ref_row, 13'(r0 + 13'h0001));
    // self refresh: own timer advances the shared row counter
    self_req = 1'h1;
    wait_mode(SDRPM_SELF);
    r0 = ref_row;
    idle(200);
    check(13'(ref_row - r0), 200 / SR_PERIOD_CYC);
    self_req = 1'h0;
    wait_mode(SDRPM_ACTIVE);
    // power-down held across a refresh slot must be broken for it
    r0 = ref_row;
    pdn_req = 1'h1;
    wait_mode(SDRPM_PDN);
    check(busy, 1'h1);
    wait_mode(SDRPM_REFRESH);
    check(ref_row, 13'(r0 + 13'h0001));
    wait_mode(SDRPM_PDN);
    pdn_req = 1'h0;
    wait_mode(SDRPM_ACTIVE);
    // deep power-down loses the array and wants a fresh start-up
    dpd_req = 1'h1;
    wait_mode(SDRPM_DPD);
    check(init_needed, 1'h1);
    idle(8);
    check(bank_open, 4'h0);
    dpd_req = 1'h0;
    wait_mode(SDRPM_ACTIVE);
    send(CMD_MRS, 2'h0, 13'h0000);
    idle(2);
    check(init_needed, 1'h0);
    give_verdict;
  end
endmodule : tb
